// ===== hw/ftpc_top.sv
/*
 * fan tachometer period counter with an AHB-Lite register slave and two channels.
 * holds the register decode, the shared reference tick prescaler and the
 * write path into the two per-fan measuring channels.
 * assumes one bus clock, a single master, word transfers, and synchronous tach inputs.
 * assumes hready is tied to hreadyout, since the slave never inserts wait states.
 * a slow fan whose pulse outlasts 255 counting steps reads ff, not a wrapped value.
 */
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module ftpc_top #(
	parameter int REF_CYC = ftpc_pkg::REF_TICK_CYC
) (
	input wire logic hclk, // bus clock, 25 MHz
	input wire logic hresetn, // asynchronous reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready in
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready, always high
	output logic hresp, // response, always okay
	input wire logic tach_first_fan_channel, // first fan tachometer
	input wire logic tach_second_fan_channel // second fan tachometer
);
	logic [15:0] pre_ff;
	logic ref_tick_ff;
	logic wr_pend_ff;
	logic [9:0] wr_idx_ff;
	logic [7:0] seed_one_ff;
	logic [7:0] seed_two_ff;
	logic [3:0] div_ff;
	logic [31:0] rdata_ff;
	logic [7:0] nxt_seed_one;
	logic [7:0] nxt_seed_two;
	logic [3:0] nxt_div;
	logic [31:0] nxt_rdata;
	logic [7:0] count_one;
	logic [7:0] count_two;
	logic settled_one;
	logic settled_two;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
		return a == b;
	endfunction : hit

	// byte-wide registers share one zero-extension
	function automatic logic [31:0] byte_word(input logic [7:0] v);
		return {24'h000000, v};
	endfunction : byte_word

	// register map, word index taken from haddr[11:2]:
	//  59 fan one count, read-only
	//  5a fan two count, read-only
	//  5b fan one seed, 5c fan two seed
	//  5d divisor: [1:0] fan one, [3:2] fan two
	//  5e status: settled flags, fan one in bit 0
	//  anything else reads zero and ignores writes
	//  upper address bits must be zero, so aliases cannot hit a register
	wire addr_phase = hsel && hready && (htrans == ftpc_pkg::HTRANS_NONSEQ);
	wire [9:0] idx = haddr[11:2];
	wire high_zero = (haddr[31:12] == 20'h00000);
	wire rd_go = addr_phase && !hwrite;
	wire wr_seed_one = wr_pend_ff && hit(wr_idx_ff, ftpc_pkg::IDX_FAN_ONE_SEED);
	wire wr_seed_two = wr_pend_ff && hit(wr_idx_ff, ftpc_pkg::IDX_FAN_TWO_SEED);
	wire wr_div = wr_pend_ff && hit(wr_idx_ff, ftpc_pkg::IDX_DIVISOR);

	assign nxt_seed_one = wr_seed_one ? hwdata[7:0] : seed_one_ff;
	assign nxt_seed_two = wr_seed_two ? hwdata[7:0] : seed_two_ff;
	assign nxt_div = wr_div ? hwdata[3:0] : div_ff;

	wire [31:0] rd_count_one = byte_word(count_one);
	wire [31:0] rd_count_two = byte_word(count_two);
	wire [31:0] rd_seed_one = byte_word(nxt_seed_one);
	wire [31:0] rd_seed_two = byte_word(nxt_seed_two);
	wire [31:0] rd_div = {28'h0000000, nxt_div};
	wire [31:0] rd_status = {30'h0, settled_two, settled_one};

	// forwarded next values keep a read straight after a write coherent
	always_comb begin
		nxt_rdata = 32'h00000000;
		if (high_zero) begin
			case (idx)
				ftpc_pkg::IDX_FAN_ONE_COUNT: begin
					nxt_rdata = rd_count_one;
				end
				ftpc_pkg::IDX_FAN_TWO_COUNT: begin
					nxt_rdata = rd_count_two;
				end
				ftpc_pkg::IDX_FAN_ONE_SEED: begin
					nxt_rdata = rd_seed_one;
				end
				ftpc_pkg::IDX_FAN_TWO_SEED: begin
					nxt_rdata = rd_seed_two;
				end
				ftpc_pkg::IDX_DIVISOR: begin
					nxt_rdata = rd_div;
				end
				ftpc_pkg::IDX_STATUS: begin
					nxt_rdata = rd_status;
				end
				default: begin
					nxt_rdata = 32'h00000000;
				end
			endcase
		end
	end

	// one shared tick keeps both channels measuring on the same time base
	wire pre_wrap = (pre_ff == 16'(REF_CYC - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_ff <= 16'h0000;
		end else if (pre_wrap) begin
			pre_ff <= 16'h0000;
		end else begin
			pre_ff <= 16'(pre_ff + 16'h0001);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_tick_ff <= 1'b0;
		end else begin
			ref_tick_ff <= pre_wrap;
		end
	end

	// a write lands in its data phase, when hwdata stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
		end else begin
			wr_pend_ff <= addr_phase && hwrite && high_zero;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_idx_ff <= 10'h000;
		end else begin
			wr_idx_ff <= idx;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seed_one_ff <= ftpc_pkg::SEED_RST;
		end else begin
			seed_one_ff <= nxt_seed_one;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seed_two_ff <= ftpc_pkg::SEED_RST;
		end else begin
			seed_two_ff <= nxt_seed_two;
		end
	end

	// divisor codes are used as stored; both fields share one word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_ff <= {ftpc_pkg::DIV_RST, ftpc_pkg::DIV_RST};
		end else begin
			div_ff <= nxt_div;
		end
	end

	// captured at the address phase, so hrdata holds until the next read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_ff <= 32'h00000000;
		end else if (rd_go) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// channels reload from the stored seed at every rise; the forwarded
	// value lets the write's own data phase reload the new seed at once
	ftpc_channel u_fan_one (
		.clk(hclk),
		.rst_n(hresetn),
		.tach(tach_first_fan_channel),
		.ref_tick(ref_tick_ff),
		.div_sel(div_ff[ftpc_pkg::DIV_ONE_LSB +: 2]),
		.seed(nxt_seed_one),
		.seed_wr(wr_seed_one),
		.count(count_one),
		.settled(settled_one)
	);

	ftpc_channel u_fan_two (
		.clk(hclk),
		.rst_n(hresetn),
		.tach(tach_second_fan_channel),
		.ref_tick(ref_tick_ff),
		.div_sel(div_ff[ftpc_pkg::DIV_TWO_LSB +: 2]),
		.seed(nxt_seed_two),
		.seed_wr(wr_seed_two),
		.count(count_two),
		.settled(settled_two)
	);

	assign hrdata = rdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule : ftpc_top

// ===== hw/ftpc_pkg.sv
/*
 * constants shared by the fan tachometer period counter: register map,
 * field layout, reset values and reference clock timing.
 * assumes a single 25 MHz bus clock feeding both the bus slave and the counters.
 */
package ftpc_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int REF_PERIOD_NS = 1000;
	localparam int REF_TICK_CYC = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [9:0] IDX_FAN_ONE_COUNT = 10'h059;
	localparam logic [9:0] IDX_FAN_TWO_COUNT = 10'h05a;
	localparam logic [9:0] IDX_FAN_ONE_SEED = 10'h05b;
	localparam logic [9:0] IDX_FAN_TWO_SEED = 10'h05c;
	localparam logic [9:0] IDX_DIVISOR = 10'h05d;
	localparam logic [9:0] IDX_STATUS = 10'h05e;

	localparam int DIV_ONE_LSB = 0;
	localparam int DIV_TWO_LSB = 2;
	localparam int STAT_ONE_BIT = 0;
	localparam int STAT_TWO_BIT = 1;

	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] SEED_RST = 8'h00;
	localparam logic [1:0] DIV_RST = 2'h0;
	localparam logic [1:0] SETTLE_PULSES = 2'h2;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : ftpc_pkg

// ===== hw/ftpc_channel.sv
/*
 * one tachometer channel: counts divided reference ticks per fan pulse and
 * latches the final count at each rising tachometer edge that does not meet a preload write.
 * assumes the tachometer input is already synchronous to clk.
 */
`timescale 1ns/1ps
module ftpc_channel (
	input wire logic clk, // bus clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic tach, // fan tachometer level
	input wire logic ref_tick, // one-cycle reference clock tick
	input wire logic [1:0] div_sel, // divisor select code
	input wire logic [7:0] seed, // preload value
	input wire logic seed_wr, // one-cycle preload write strobe
	output logic [7:0] count, // latched count of last pulse
	output logic settled // two pulses seen since preload
);
	logic tach_ff;
	logic [7:0] run_ff;
	logic [7:0] count_ff;
	logic [2:0] sub_ff;
	logic [1:0] settle_ff;
	wire rise = tach & ~tach_ff;
	wire [2:0] sub_top = 3'((4'h1 << div_sel) - 4'h1);
	wire step = ref_tick && (sub_ff >= sub_top);
	wire [7:0] run_inc = (run_ff == 8'hff) ? run_ff : 8'(run_ff + 8'h01);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tach_ff <= 1'b0;
		end else begin
			tach_ff <= tach;
		end
	end

	// preload write wins over a coincident edge: that pulse is discarded
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_ff <= ftpc_pkg::SEED_RST;
			sub_ff <= 3'h0;
		end else if (seed_wr || rise) begin
			run_ff <= seed;
			sub_ff <= 3'h0;
		end else if (step) begin
			run_ff <= run_inc;
			sub_ff <= 3'h0;
		end else if (ref_tick) begin
			sub_ff <= 3'(sub_ff + 3'h1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= ftpc_pkg::COUNT_RST;
		end else if (rise && !seed_wr) begin
			count_ff <= run_ff;
		end
	end

	// first latch after a preload holds a partial pulse, so two are needed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_ff <= 2'h0;
		end else if (seed_wr) begin
			settle_ff <= 2'h0;
		end else if (rise && settle_ff != ftpc_pkg::SETTLE_PULSES) begin
			settle_ff <= 2'(settle_ff + 2'h1);
		end
	end

	assign count = count_ff;
	assign settled = (settle_ff == ftpc_pkg::SETTLE_PULSES);
endmodule : ftpc_channel

// ===== verification/ftpc_monitor.sv
/* port checker for the fan tachometer period counter.
 assumes single word transfers and a bind onto ftpc_top. */
`timescale 1ns/1ps
module ftpc_monitor #(
	parameter int REF_CYC = 25
) (
	input wire logic hclk, // bus clock
	input wire logic hresetn, // reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write flag
	input wire logic [31:0] hwdata, // write data
	input wire logic [31:0] hrdata, // read data
	input wire logic hreadyout, // slave ready
	input wire logic hresp // response
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence acc(logic [9:0] idx, logic w);
		hsel && htrans == ftpc_pkg::HTRANS_NONSEQ && hwrite == w && haddr == {20'h0, idx, 2'h0};
	endsequence
	chk_ready_high: assert property (hreadyout) else $error("ready low");
	chk_resp_okay: assert property (!hresp) else $error("resp not okay");
	chk_rst_zero: assert property ($rose(hresetn) |-> hrdata == 32'h0)
		else $error("read data not zero after reset");
	chk_one_width: assert property (acc(ftpc_pkg::IDX_FAN_ONE_COUNT, 1'b0) |=>
		hrdata[31:8] == 24'h0) else $error("count one upper bits set");
	chk_two_width: assert property (acc(ftpc_pkg::IDX_FAN_TWO_COUNT, 1'b0) |=>
		hrdata[31:8] == 24'h0) else $error("count two upper bits set");
	chk_seed_back: assert property (acc(ftpc_pkg::IDX_FAN_TWO_SEED, 1'b1) ##2
		acc(ftpc_pkg::IDX_FAN_TWO_SEED, 1'b0) |=> hrdata[7:0] == $past(hwdata[7:0], 2))
		else $error("seed two read back wrong");
	chk_div_back: assert property (acc(ftpc_pkg::IDX_DIVISOR, 1'b1) ##2
		acc(ftpc_pkg::IDX_DIVISOR, 1'b0) |=> hrdata[3:0] == $past(hwdata[3:0], 2))
		else $error("divisor read back wrong");
	chk_seed_clears: assert property (acc(ftpc_pkg::IDX_FAN_ONE_SEED, 1'b1) ##2
		acc(ftpc_pkg::IDX_STATUS, 1'b0) |=> !hrdata[0]) else $error("settled kept");
endmodule : ftpc_monitor
bind ftpc_top ftpc_monitor #(.REF_CYC(REF_CYC)) u_ftpc_monitor (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// ===== verification/ftpc_fan_model.sv
/* fan tachometer model: square wave of a fixed period.
 assumes a period of at least two cycles. */
`timescale 1ns/1ps
module ftpc_fan_model (
	input wire logic clk, // bus clock
	input wire logic [15:0] period, // cycles rise to rise
	output logic tach // tachometer level
);
	logic [15:0] cnt_ff = 16'h0;
	initial tach = 1'b0;
	always @(posedge clk) begin
		cnt_ff <= (cnt_ff + 16'h1 >= period) ? 16'h0 : cnt_ff + 16'h1;
		tach <= cnt_ff < (period >> 1);
	end
endmodule : ftpc_fan_model

// ===== verification/test_fan_tach_period_counter.sv
/* testbench for ftpc_top: registers over the bus, two free-running fans.
 assumes zero-wait slave; counts allowed one counting step of phase error. */
`timescale 1ns/1ps
module test_fan_tach_period_counter;
	localparam int R = 2;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, t1, t2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	int n_fail = 0, tests_run = 0, cyc = 0, s1, s2, e;
	int exp_q[$];
	function automatic int model_count(input int seed, input int period, input int d);
		int n;
		n = seed + period / (R << d);
		return (n > 255) ? 255 : n;
	endfunction : model_count
	ftpc_top #(.REF_CYC(R)) u_ftpc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tach_first_fan_channel(t1), .tach_second_fan_channel(t2));
	ftpc_fan_model u_fan_one (.clk(hclk), .period(16'd64), .tach(t1));
	ftpc_fan_model u_fan_two (.clk(hclk), .period(16'd48), .tach(t2));
	initial forever #20 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic bus(input logic [9:0] i, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic check(input string n, input int x, input logic [31:0] g, input int tol);
		tests_run++;
		if (^g === 1'bx || g + tol < x || g > x + tol) begin
			n_fail++;
			$display("Error %s expected %0d got %0d", n, x, g);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		e = $urandom(44677);
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 'h59; i <= 'h5f; i++) begin
			bus(10'(i), 1'b0, 32'h0);
			check("reset read", 0, rd, 0);
		end
		$display("test reset done");
		// seed f0 on the first pass drives the count into saturation
		for (int d = 0; d < 4; d++) begin
			s1 = (d == 0) ? 'hf0 : $urandom % 128;
			s2 = $urandom % 128;
			bus(ftpc_pkg::IDX_FAN_TWO_SEED, 1'b1, 32'(s2));
			bus(ftpc_pkg::IDX_FAN_TWO_SEED, 1'b0, 32'h0);
			check("seed two", s2, rd, 0);
			bus(ftpc_pkg::IDX_DIVISOR, 1'b1, 32'(d * 5));
			bus(ftpc_pkg::IDX_DIVISOR, 1'b0, 32'h0);
			check("divisor", d * 5, rd, 0);
			bus(ftpc_pkg::IDX_FAN_ONE_SEED, 1'b1, 32'(s1));
			bus(ftpc_pkg::IDX_STATUS, 1'b0, 32'h0);
			check("status early", 0, rd, 0);
			// random extra wait samples the latch at any point of a pulse
			repeat (256 + $urandom % 64) @(posedge hclk);
			bus(ftpc_pkg::IDX_STATUS, 1'b0, 32'h0);
			check("status settled", 3, rd, 0);
			bus(ftpc_pkg::IDX_FAN_ONE_SEED, 1'b0, 32'h0);
			check("seed one", s1, rd, 0);
			bus(ftpc_pkg::IDX_FAN_ONE_COUNT, 1'b1, 32'hff);
			exp_q.push_back(model_count(s1, 64, d));
			exp_q.push_back(model_count(s2, 48, d));
			bus(ftpc_pkg::IDX_FAN_ONE_COUNT, 1'b0, 32'h0);
			check("count one", exp_q.pop_front(), rd, 1);
			bus(ftpc_pkg::IDX_FAN_TWO_COUNT, 1'b0, 32'h0);
			check("count two", exp_q.pop_front(), rd, 1);
			$display("test divisor %0d done", d);
		end
		end_of_test();
	end
endmodule : test_fan_tach_period_counter
